//--- design/pwm_setting_pkg.sv
// Constants for the three-phase PWM output setting block.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
// Notes on behaviour
// - Three 16-bit read/write duty values, any value; upper bits read zero.
// - V-phase duty occupies bits 15 to 0, all values allowed.
// - W-phase duty occupies bits 15 to 0, all values allowed.
// - Output-control task 0 or 9 overwrites the three duty values.
// - Current duty values feed trigger-generation task 1.
// - Task 0 or 9 overwrites drive control; bits 31 to 9 read zero.
// - Mode bits W8, V7, U6: 0 static on/off, 1 PWM drive.
// - W field bits 5-4: 00 off, 01 complement, 10 primary, 11 both.
// - V field bits 3-2 decoded the same way as the W field.
// - U field bits 1-0 decoded the same way as the W field.
// - PWM mode enables both outputs of the phase regardless of field.
// - PWM field 00 gives inverted primary; field 11 gives true primary.
package pwm_setting_pkg;
  localparam logic [3:0]  ADDR_U_DUTY      = 4'h0;
  localparam logic [3:0]  ADDR_V_DUTY      = 4'h4;
  localparam logic [3:0]  ADDR_W_DUTY      = 4'h8;
  localparam logic [3:0]  ADDR_DRIVE_CTRL  = 4'hC;
  localparam int          DUTY_W           = 16;
  localparam int          CTRL_W           = 9;
  localparam int          U_MODE_BIT       = 6;
  localparam int          V_MODE_BIT       = 7;
  localparam int          W_MODE_BIT       = 8;
  localparam int          U_FIELD_LSB      = 0;
  localparam int          V_FIELD_LSB      = 2;
  localparam int          W_FIELD_LSB      = 4;
  localparam logic [3:0]  TASK_OUT_A       = 4'h0;
  localparam logic [3:0]  TASK_OUT_B       = 4'h9;
  localparam logic [3:0]  TASK_TRIGGER     = 4'h1;
  localparam logic [15:0] DUTY_RESET       = 16'h0000;
  localparam logic [8:0]  CTRL_RESET       = 9'h000;
  localparam logic [1:0]  FIELD_OFF        = 2'h0;
  localparam logic [1:0]  FIELD_COMP       = 2'h1;
  localparam logic [1:0]  FIELD_PRIM       = 2'h2;
  localparam logic [1:0]  FIELD_BOTH       = 2'h3;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage : pwm_setting_pkg

//--- design/phase_drive.sv
// One phase's output pair driver with registered outputs.
// Assumes the PWM wave is synchronous to clk_in.
module phase_drive
  import pwm_setting_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       mode_in,
  input  wire logic [1:0] field_in,
  input  wire logic       wave_in,
  output logic            primary_out,
  output logic            complement_out,
  output logic            primary_en_out,
  output logic            complement_en_out
);

  ////////////////////////////////////////////////////////////////////////
  // mode selects drive
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      primary_out       <= 1'b0;
      complement_out    <= 1'b0;
      primary_en_out    <= 1'b0;
      complement_en_out <= 1'b0;
    end else if (mode_in) begin
      primary_en_out    <= 1'b1;
      complement_en_out <= 1'b1;
      primary_out       <= (field_in == FIELD_BOTH) ? wave_in : ~wave_in;
      complement_out    <= (field_in == FIELD_BOTH) ? ~wave_in : wave_in;
    end else begin
      primary_en_out    <= field_in[1];
      complement_en_out <= field_in[0];
      primary_out       <= field_in[1];
      complement_out    <= field_in[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_static_off : assert property (@(posedge clk_in) disable iff (rst_in)
    (!mode_in && field_in == FIELD_OFF) |=> (!primary_out && !complement_out))
    else $error("static off not both low");
  a_pwm_both_en : assert property (@(posedge clk_in) disable iff (rst_in)
    mode_in |=> (primary_en_out && complement_en_out))
    else $error("pwm mode did not enable both");
  a_pwm_inverse : assert property (@(posedge clk_in) disable iff (rst_in)
    mode_in |=> (primary_out != complement_out))
    else $error("pwm pair not complementary");
  a_pwm_true_11 : assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_in && field_in == FIELD_BOTH) |=> (primary_out == $past(wave_in)))
    else $error("field 11 primary not true wave");
  a_static_comp : assert property (@(posedge clk_in) disable iff (rst_in)
    (!mode_in && field_in == FIELD_COMP) |=> (!primary_en_out && complement_en_out))
    else $error("field 01 wrong enables");
  a_static_prim : assert property (@(posedge clk_in) disable iff (rst_in)
    (!mode_in && field_in == FIELD_PRIM) |=> (primary_en_out && !complement_en_out))
    else $error("field 10 wrong enables");
endmodule : phase_drive

//--- design/three_phase_pwm_output_setting.sv
// Register file and six-output drive stage for three-phase PWM settings.
// Assumes an Avalon-MM master, a task port from the accelerator, and PWM waves on clk_in.
module three_phase_pwm_output_setting
  import pwm_setting_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        task_valid_in,
  input  wire logic [3:0]  task_number_in,
  input  wire logic [15:0] task_u_duty_in,
  input  wire logic [15:0] task_v_duty_in,
  input  wire logic [15:0] task_w_duty_in,
  input  wire logic [8:0]  task_drive_ctrl_in,
  output logic             trigger_task_out,
  output logic [15:0]      trigger_u_duty_out,
  output logic [15:0]      trigger_v_duty_out,
  output logic [15:0]      trigger_w_duty_out,
  input  wire logic        u_phase_pwm_wave_in,
  input  wire logic        v_phase_pwm_wave_in,
  input  wire logic        w_phase_pwm_wave_in,
  output logic             u_phase_primary_out,
  output logic             u_phase_complement_out,
  output logic             v_phase_primary_out,
  output logic             v_phase_complement_out,
  output logic             w_phase_primary_out,
  output logic             w_phase_complement_out,
  output logic [5:0]       drive_enable_out
);

  logic [15:0] u_phase_duty_r;
  logic [15:0] v_phase_duty_r;
  logic [15:0] w_phase_duty_r;
  logic [8:0]  six_output_drive_control_r;
  bus_state_t  bus_state_r;
  logic        bus_hit;
  logic        task_out_hit;
  logic [5:0]  pin_out;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d, input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old_v[15:8], be[0] ? d[7:0] : old_v[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////
  // Each access waits one cycle, then completes on the second edge.
  assign bus_hit      = (avs_read_in || avs_write_in) && (bus_state_r == BUS_ACK);
  assign task_out_hit = task_valid_in && (task_number_in == TASK_OUT_A || task_number_in == TASK_OUT_B);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      case (bus_state_r)
        BUS_IDLE: bus_state_r <= (avs_read_in || avs_write_in) ? BUS_ACK : BUS_IDLE;
        BUS_ACK:  bus_state_r <= BUS_IDLE;
        default:  bus_state_r <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && bus_state_r == BUS_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Task writes take priority over a software write in the same cycle.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      u_phase_duty_r <= DUTY_RESET;
      v_phase_duty_r <= DUTY_RESET;
      w_phase_duty_r <= DUTY_RESET;
    end else if (task_out_hit) begin
      u_phase_duty_r <= task_u_duty_in;
      v_phase_duty_r <= task_v_duty_in;
      w_phase_duty_r <= task_w_duty_in;
    end else if (bus_hit && avs_write_in) begin
      if (avs_address_in == ADDR_U_DUTY) begin
        u_phase_duty_r <= merge16(u_phase_duty_r, avs_writedata_in, avs_byteenable_in);
      end
      if (avs_address_in == ADDR_V_DUTY) begin
        v_phase_duty_r <= merge16(v_phase_duty_r, avs_writedata_in, avs_byteenable_in);
      end
      if (avs_address_in == ADDR_W_DUTY) begin
        w_phase_duty_r <= merge16(w_phase_duty_r, avs_writedata_in, avs_byteenable_in);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      six_output_drive_control_r <= CTRL_RESET;
    end else if (task_out_hit) begin
      six_output_drive_control_r <= task_drive_ctrl_in;
    end else if (bus_hit && avs_write_in && avs_address_in == ADDR_DRIVE_CTRL) begin
      if (avs_byteenable_in[0]) begin
        six_output_drive_control_r[7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        six_output_drive_control_r[8] <= avs_writedata_in[8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && bus_state_r == BUS_IDLE) begin
      // Read data load on the first edge so that they stand when waitrequest is sampled low.
      // upper bits zero
      case (avs_address_in)
        ADDR_U_DUTY:     avs_readdata_out <= {16'h0000, u_phase_duty_r};
        ADDR_V_DUTY:     avs_readdata_out <= {16'h0000, v_phase_duty_r};
        ADDR_W_DUTY:     avs_readdata_out <= {16'h0000, w_phase_duty_r};
        ADDR_DRIVE_CTRL: avs_readdata_out <= {23'h000000, six_output_drive_control_r};
        default:         avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // duty to trigger
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trigger_task_out   <= 1'b0;
      trigger_u_duty_out <= DUTY_RESET;
      trigger_v_duty_out <= DUTY_RESET;
      trigger_w_duty_out <= DUTY_RESET;
    end else begin
      trigger_task_out   <= task_valid_in && task_number_in == TASK_TRIGGER;
      trigger_u_duty_out <= u_phase_duty_r;
      trigger_v_duty_out <= v_phase_duty_r;
      trigger_w_duty_out <= w_phase_duty_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // U, V and W field decode
  phase_drive u_drive (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .mode_in           (six_output_drive_control_r[U_MODE_BIT]),
    .field_in          (six_output_drive_control_r[U_FIELD_LSB +: 2]),
    .wave_in           (u_phase_pwm_wave_in),
    .primary_out       (pin_out[0]),
    .complement_out    (pin_out[1]),
    .primary_en_out    (drive_enable_out[0]),
    .complement_en_out (drive_enable_out[1])
  );
  phase_drive v_drive (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .mode_in           (six_output_drive_control_r[V_MODE_BIT]),
    .field_in          (six_output_drive_control_r[V_FIELD_LSB +: 2]),
    .wave_in           (v_phase_pwm_wave_in),
    .primary_out       (pin_out[2]),
    .complement_out    (pin_out[3]),
    .primary_en_out    (drive_enable_out[2]),
    .complement_en_out (drive_enable_out[3])
  );
  phase_drive w_drive (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .mode_in           (six_output_drive_control_r[W_MODE_BIT]),
    .field_in          (six_output_drive_control_r[W_FIELD_LSB +: 2]),
    .wave_in           (w_phase_pwm_wave_in),
    .primary_out       (pin_out[4]),
    .complement_out    (pin_out[5]),
    .primary_en_out    (drive_enable_out[4]),
    .complement_en_out (drive_enable_out[5])
  );

  assign u_phase_primary_out    = pin_out[0];
  assign u_phase_complement_out = pin_out[1];
  assign v_phase_primary_out    = pin_out[2];
  assign v_phase_complement_out = pin_out[3];
  assign w_phase_primary_out    = pin_out[4];
  assign w_phase_complement_out = pin_out[5];

  ////////////////////////////////////////////////////////////////////////
  a_task_duty : assert property (@(posedge clk_in) disable iff (rst_in)
    task_out_hit |=> (u_phase_duty_r == $past(task_u_duty_in) && w_phase_duty_r == $past(task_w_duty_in)))
    else $error("task did not load duty");
  a_task_ctrl : assert property (@(posedge clk_in) disable iff (rst_in)
    task_out_hit |=> (six_output_drive_control_r == $past(task_drive_ctrl_in)))
    else $error("task did not load control");
  a_trig_duty : assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> (trigger_v_duty_out == $past(v_phase_duty_r)))
    else $error("trigger duty stale");
  a_rd_upper_zero : assert property (@(posedge clk_in) disable iff (rst_in)
    avs_readdata_out[31:16] == 16'h0000)
    else $error("duty upper bits nonzero");
  sequence s_bus_first;
    (avs_read_in || avs_write_in) && (bus_state_r == BUS_IDLE);
  endsequence
  sequence s_bus_answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_ack_two_cycle : assert property (@(posedge clk_in) disable iff (rst_in)
    s_bus_first |=> s_bus_answer)
    else $error("access not acked after one cycle");
  a_rd_data_stand : assert property (@(posedge clk_in) disable iff (rst_in)
    (avs_read_in && bus_state_r == BUS_IDLE && avs_address_in == ADDR_U_DUTY)
      |=> (avs_readdata_out == {16'h0000, $past(u_phase_duty_r)}))
    else $error("read data not standing at acknowledge");
endmodule : three_phase_pwm_output_setting

//--- verif/pwm_unit_model.sv
// Behavioural model of the motor PWM output unit on the far side of the block.
// Assumes the duty copies from the block and the same clock; waves change just after a rising edge.
module pwm_unit_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] u_duty_in,
  input  wire logic [15:0] v_duty_in,
  input  wire logic [15:0] w_duty_in,
  output logic [2:0]       wave_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  always_ff @(posedge clk_in) begin
    if (rst_in)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end
  assign wave_out = {cnt_r < w_duty_in[3:0], cnt_r < v_duty_in[3:0], cnt_r < u_duty_in[3:0]};
endmodule : pwm_unit_model

//--- verif/testbench.sv
// Self-checking bench for the three-phase PWM output setting block.
// Assumes an Avalon-MM master, a task port driver and the PWM unit model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_setting_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, avs_read = 1'b0, avs_write = 1'b0, tvalid = 1'b0, trig;
  logic [3:0]  avs_address = 4'h0, tnum = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, rdata, q;
  logic [15:0] du = 16'h0, dv = 16'h0, dw = 16'h0, tu, tv, tw;
  logic [8:0]  tctrl = 9'h000;
  logic        wreq;
  logic [5:0]  pins, en;
  logic [2:0]  waves;
  int          n_mismatch = 0, tests_run = 0, cycles = 0;
  always #5 clk_in = ~clk_in;
  three_phase_pwm_output_setting u_three_phase_pwm_output_setting (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .task_valid_in(tvalid), .task_number_in(tnum), .task_u_duty_in(du),
    .task_v_duty_in(dv), .task_w_duty_in(dw), .task_drive_ctrl_in(tctrl), .trigger_task_out(trig),
    .trigger_u_duty_out(tu), .trigger_v_duty_out(tv), .trigger_w_duty_out(tw),
    .u_phase_pwm_wave_in(waves[0]), .v_phase_pwm_wave_in(waves[1]), .w_phase_pwm_wave_in(waves[2]),
    .u_phase_primary_out(pins[0]), .u_phase_complement_out(pins[1]), .v_phase_primary_out(pins[2]),
    .v_phase_complement_out(pins[3]), .w_phase_primary_out(pins[4]), .w_phase_complement_out(pins[5]),
    .drive_enable_out(en));
  pwm_unit_model u_pwm_unit_model (.clk_in(clk_in), .rst_in(rst_in), .u_duty_in(tu), .v_duty_in(tv),
    .w_duty_in(tw), .wave_out(waves));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("TB: compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      chk(32'h1, 32'h0);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic send_task(input logic [3:0] n, input logic [15:0] u, v, w, input logic [8:0] c);
    @(posedge clk_in);
    tvalid <= 1'b1;
    tnum <= n;
    du <= u;
    dv <= v;
    dw <= w;
    tctrl <= c;
    @(posedge clk_in);
    tvalid <= 1'b0;
  endtask : send_task
  // Expected {complement, primary} level of one phase.
  function automatic logic [1:0] pair(input logic m, input logic [1:0] f, input logic w);
    if (!m)
      return {f[0], f[1]};
    if (f == FIELD_BOTH)
      return {~w, w};
    return {w, ~w};
  endfunction : pair
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({26'h0, pins}, 32'h0);
    chk({26'h0, en}, 32'h0);
    for (int i = 0; i < 4; i++)
      rd(4'(4 * i), 32'h0);
    $display("TB: reset test done");
  endtask : t_reset
  task automatic t_regs;
    logic [3:0] a[3] = '{ADDR_U_DUTY, ADDR_V_DUTY, ADDR_W_DUTY};
    foreach (a[i]) begin
      bus(1'b1, a[i], 32'hFFFFFFFF);
      rd(a[i], 32'h0000FFFF);
      bus(1'b1, a[i], 32'h00000000);
      rd(a[i], 32'h0);
    end
    bus(1'b1, ADDR_DRIVE_CTRL, 32'hFFFFFFFF);
    rd(ADDR_DRIVE_CTRL, 32'h000001FF);
    bus(1'b1, ADDR_DRIVE_CTRL, 32'hFFFFFE00);
    rd(ADDR_DRIVE_CTRL, 32'h0);
    avs_byteenable <= 4'h2;
    bus(1'b1, ADDR_W_DUTY, 32'hFFFFFFFF);
    rd(ADDR_W_DUTY, 32'h0000FF00);
    bus(1'b1, ADDR_DRIVE_CTRL, 32'hFFFFFFFF);
    rd(ADDR_DRIVE_CTRL, 32'h00000100);
    avs_byteenable <= 4'hF;
    bus(1'b1, ADDR_DRIVE_CTRL, 32'h00000000);
    bus(1'b1, 4'h6, 32'hFFFFFFFF);
    rd(4'h6, 32'h0);
    rd(ADDR_V_DUTY, 32'h0);
    $display("TB: register test done");
  endtask : t_regs
  task automatic t_tasks;
    send_task(TASK_OUT_A, 16'hA5A7, 16'h5A55, 16'hFFFA, 9'h1FF);
    rd(ADDR_U_DUTY, 32'h0000A5A7);
    rd(ADDR_DRIVE_CTRL, 32'h000001FF);
    send_task(TASK_OUT_B, 16'h1239, 16'h8005, 16'h000B, 9'h0A5);
    rd(ADDR_V_DUTY, 32'h00008005);
    rd(ADDR_DRIVE_CTRL, 32'h000000A5);
    send_task(TASK_TRIGGER, 16'h0, 16'h0, 16'h0, 9'h0);
    @(negedge clk_in);
    chk({31'h0, trig}, 32'h1);
    chk({tw, tv}, 32'h000B8005);
    chk({16'h0, tu}, 32'h00001239);
    @(negedge clk_in);
    chk({31'h0, trig}, 32'h0);
    rd(ADDR_W_DUTY, 32'h0000000B);
    // A task taken at the edge where a bus write lands must win.
    fork
      bus(1'b1, ADDR_U_DUTY, 32'h00001111);
      begin
        @(posedge clk_in);
        send_task(TASK_OUT_B, 16'h2222, 16'h8005, 16'h000B, 9'h0A5);
      end
    join
    rd(ADDR_U_DUTY, 32'h00002222);
    $display("TB: task test done");
  endtask : t_tasks
  task automatic t_drive;
    logic [2:0]  w;
    logic [5:0]  ep, ee;
    for (int m = 0; m < 2; m++)
      for (int f = 0; f < 4; f++) begin
        bus(1'b1, ADDR_DRIVE_CTRL, {23'h0, {3{1'(m)}}, {3{2'(f)}}});
        repeat (3) @(negedge clk_in);
        repeat (4) begin
          w = waves;
          @(negedge clk_in);
          for (int p = 0; p < 3; p++) begin
            ep[2*p+:2] = pair(1'(m), 2'(f), w[p]);
            ee[2*p+:2] = m ? 2'h3 : {1'(f), 1'(f >> 1)};
          end
          chk({26'h0, pins}, {26'h0, ep});
          chk({26'h0, en}, {26'h0, ee});
        end
      end
    $display("TB: drive test done");
  endtask : t_drive
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_regs();
    t_tasks();
    t_drive();
    end_of_test();
  end
endmodule : testbench
